// File: rtl/pms_path_monitor_sink.sv
// VC-3 path overhead monitor sink with APB registers and interrupt
`timescale 1ns/100ps
`default_nettype none

module pms_path_monitor_sink
    import pms_pkg::*;
#(
    parameter int unsigned CNT_W = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_stream_clk,
    input wire logic [7:0] i_stream_data,
    input wire logic i_frame_start,
    input wire logic i_server_signal_fail_in,
    input wire logic i_equipment_defect,
    input wire logic i_one_second,
    output logic [7:0] o_data,
    output logic o_data_valid,
    output logic o_frame_start,
    output logic o_trail_signal_fail_out,
    output logic o_trail_signal_degrade_out,
    output logic o_remote_defect_to_source,
    output logic [3:0] o_remote_error_to_source,
    output logic o_irq
);

    // Run length of matching frames, saturating
    function automatic logic [2:0] run_next(input logic [2:0] cnt, input logic hit);
        if (!hit) begin
            return 3'h0;
        end
        return (cnt == 3'h7) ? cnt : cnt + 3'h1;
    endfunction

    // Number of set bits in a byte
    function automatic logic [3:0] ones8(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    pms_stream_s in_raw; // Pins gathered
    pms_stream_s sync1; // First stage, read only by sync2
    pms_stream_s sync2;
    pms_stream_s sync3;
    logic clk_f; // Filtered stream clock level
    logic ssf_f; // Filtered server fail level
    logic byte_edge; // One cycle per stream byte
    logic [7:0] rx_byte;
    logic rx_fs;

    assign in_raw = {i_stream_clk, i_frame_start, i_server_signal_fail_in, i_stream_data};

    // Three-stage synchroniser for every stream pin
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= in_raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Levels move only when stages two and three agree
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clk_f <= 1'b0;
            ssf_f <= 1'b0;
        end else begin
            if (sync2.clk == sync3.clk) begin
                clk_f <= sync3.clk;
            end
            if (sync2.ssf == sync3.ssf) begin
                ssf_f <= sync3.ssf;
            end
        end
    end

    // rising stream clock
    // Data settles long before the edge, so stage three is safe to take
    assign byte_edge = sync2.clk & sync3.clk & ~clk_f;
    assign rx_byte = sync3.data;
    assign rx_fs = sync3.fs;

    pms_frame_e frame_state;
    logic [6:0] col; // Column of the next byte
    logic [3:0] row; // Row of the next byte
    logic [6:0] cur_col;
    logic [3:0] cur_row;
    logic aligned;
    logic is_trace, is_parity, is_label, is_status;

    assign cur_col = rx_fs ? 7'h00 : col;
    assign cur_row = rx_fs ? 4'h0 : row;
    assign aligned = rx_fs | (frame_state != FR_HUNT);
    assign is_trace = aligned && cur_col == 7'h00 && cur_row == ROW_TRACE;
    assign is_parity = aligned && cur_col == 7'h00 && cur_row == ROW_PARITY;
    assign is_label = aligned && cur_col == 7'h00 && cur_row == ROW_LABEL;
    assign is_status = aligned && cur_col == 7'h00 && cur_row == ROW_STATUS;

    // Byte position counters and alignment state
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            col <= 7'h00;
            row <= 4'h0;
            frame_state <= FR_HUNT;
        end else if (byte_edge) begin
            if (cur_col == LAST_COL) begin
                col <= 7'h00;
                row <= (cur_row == LAST_ROW) ? 4'h0 : cur_row + 4'h1;
            end else begin
                col <= cur_col + 7'h01;
                row <= cur_row;
            end
            if (rx_fs) begin
                case (frame_state)
                    FR_HUNT: frame_state <= FR_FIRST;
                    FR_FIRST: frame_state <= FR_LOCKED;
                    FR_LOCKED: frame_state <= FR_LOCKED;
                    default: frame_state <= FR_HUNT;
                endcase
            end
        end
    end

    logic [7:0] bip_acc; // Parity of the frame in progress
    logic [7:0] bip_prev; // Parity of the previous frame
    logic [3:0] pv_cnt; // Violations in this frame's parity byte
    logic ev_near; // Near-end errored block
    logic ev_far; // Far-end errored block
    logic [3:0] rei_code;

    assign pv_cnt = ones8(bip_prev ^ rx_byte);
    // any violation is an errored block
    // The first frame after alignment has no complete predecessor
    assign ev_near = byte_edge & is_parity & (frame_state == FR_LOCKED) & (pv_cnt != 4'h0);
    // only bits 1 to 4 are looked at
    assign rei_code = rx_byte[REI_MSB:REI_LSB];
    // codes 1..8 count one, others none
    assign ev_far = byte_edge & is_status & (rei_code != 4'h0) & (rei_code <= REI_MAX);

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bip_acc <= 8'h00;
            bip_prev <= 8'h00;
        end else if (byte_edge) begin
            if (rx_fs) begin
                bip_prev <= bip_acc;
                bip_acc <= rx_byte;
            end else begin
                bip_acc <= bip_acc ^ rx_byte;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_remote_error_to_source <= 4'h0;
        end else if (byte_edge && is_parity) begin
            o_remote_error_to_source <= (frame_state == FR_LOCKED) ? pv_cnt : 4'h0;
        end
    end

    logic [7:0] rx_trace; // Latest trace byte
    logic [7:0] acc_trace; // Accepted trace byte
    logic acc_trace_ok;
    logic [2:0] trace_run;
    logic [7:0] rx_label;
    logic [7:0] acc_label;
    logic acc_label_ok;
    logic [2:0] label_run;
    logic remote_defect;
    logic [2:0] rdi_run;
    logic [2:0] next_trace_run;
    logic [2:0] next_label_run;
    logic [2:0] next_rdi_run;

    assign next_trace_run = run_next(trace_run, rx_byte == rx_trace && frame_state != FR_HUNT);
    assign next_label_run = run_next(label_run, rx_byte == rx_label && frame_state != FR_HUNT);
    assign next_rdi_run = run_next(rdi_run, rx_byte[RDI_BIT] != remote_defect);

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_trace <= 8'h00;
            acc_trace <= 8'h00;
            acc_trace_ok <= 1'b0;
            trace_run <= 3'h0;
        end else if (byte_edge && is_trace) begin
            rx_trace <= rx_byte;
            trace_run <= next_trace_run;
            if (next_trace_run >= TRACE_PERSIST - 3'h1) begin
                acc_trace <= rx_byte;
                acc_trace_ok <= 1'b1;
            end
        end
    end

    // signal label accepted after repeated frames
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_label <= 8'h00;
            acc_label <= 8'h00;
            acc_label_ok <= 1'b0;
            label_run <= 3'h0;
        end else if (byte_edge && is_label) begin
            rx_label <= rx_byte;
            label_run <= next_label_run;
            if (next_label_run >= LABEL_PERSIST - 3'h1) begin
                acc_label <= rx_byte;
                acc_label_ok <= 1'b1;
            end
        end
    end

    // remote defect flips after persistent change
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            remote_defect <= 1'b0;
            rdi_run <= 3'h0;
        end else if (byte_edge && is_status) begin
            if (next_rdi_run >= RDI_PERSIST) begin
                remote_defect <= ~remote_defect;
                rdi_run <= 3'h0;
            end else begin
                rdi_run <= next_rdi_run;
            end
        end
    end

    // Configuration registers
    logic ctrl_mon, ctrl_ssf_en, ctrl_rdi_en, ctrl_tim_dis, ctrl_fmt;
    logic [7:0] exp_trace;
    logic [15:0] deg_thr;
    logic [3:0] deg_m;
    logic unequipped, trace_mismatch, degrade;

    assign unequipped = acc_label_ok && acc_label == UNEQ_LABEL;
    assign trace_mismatch = acc_trace_ok && !ctrl_tim_dis && (ctrl_fmt ?
        acc_trace[6:0] != exp_trace[6:0] : acc_trace != exp_trace);

    logic [CNT_W-1:0] near_cnt, far_cnt; // Running counts this second
    logic near_ds_acc, far_ds_acc; // Defect seen this second
    logic [CNT_W-1:0] pm_nebc, pm_febc;
    logic pm_nds, pm_fds;
    logic [3:0] bad_run, good_run;
    logic trail_fail;

    assign trail_fail = ssf_f | unequipped | trace_mismatch;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            near_cnt <= '0;
            far_cnt <= '0;
            near_ds_acc <= 1'b0;
            far_ds_acc <= 1'b0;
            pm_nebc <= '0;
            pm_febc <= '0;
            pm_nds <= 1'b0;
            pm_fds <= 1'b0;
        end else if (i_one_second) begin
            pm_nebc <= near_cnt + CNT_W'(ev_near);
            pm_febc <= far_cnt + CNT_W'(ev_far);
            pm_nds <= near_ds_acc | trail_fail | i_equipment_defect;
            pm_fds <= far_ds_acc | remote_defect;
            near_cnt <= '0;
            far_cnt <= '0;
            near_ds_acc <= 1'b0;
            far_ds_acc <= 1'b0;
        end else begin
            near_cnt <= near_cnt + CNT_W'(ev_near);
            far_cnt <= far_cnt + CNT_W'(ev_far);
            near_ds_acc <= near_ds_acc | trail_fail | i_equipment_defect;
            far_ds_acc <= far_ds_acc | remote_defect;
        end
    end

    // degrade over consecutive bad seconds
    // A window count of zero behaves as one
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            degrade <= 1'b0;
            bad_run <= 4'h0;
            good_run <= 4'h0;
        end else if (i_one_second) begin
            if ((near_cnt + CNT_W'(ev_near)) >= CNT_W'(deg_thr)) begin
                good_run <= 4'h0;
                bad_run <= (bad_run == 4'hf) ? bad_run : bad_run + 4'h1;
                if (bad_run + 4'h1 >= deg_m) begin
                    degrade <= 1'b1;
                end
            end else begin
                bad_run <= 4'h0;
                good_run <= (good_run == 4'hf) ? good_run : good_run + 4'h1;
                if (good_run + 4'h1 >= deg_m) begin
                    degrade <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_trail_signal_fail_out <= 1'b0;
            o_remote_defect_to_source <= 1'b0;
            o_trail_signal_degrade_out <= 1'b0;
        end else begin
            o_trail_signal_fail_out <= trail_fail;
            o_remote_defect_to_source <= trail_fail;
            o_trail_signal_degrade_out <= degrade;
        end
    end

    // all-ones replaces data immediately
    // Acting on the next byte keeps far inside the allowed time
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_data <= 8'h00;
            o_frame_start <= 1'b0;
            o_data_valid <= 1'b0;
        end else begin
            o_data_valid <= byte_edge;
            if (byte_edge) begin
                o_data <= (unequipped | trace_mismatch) ? ALL_ONES : rx_byte;
                o_frame_start <= rx_fs;
            end
        end
    end

    pms_report_s rpt, next_rpt, rpt_prev;

    always_comb begin
        next_rpt.uneq = unequipped & ctrl_mon;
        next_rpt.tim = trace_mismatch & ~unequipped & ctrl_mon;
        next_rpt.deg = degrade & ~trace_mismatch & ctrl_mon;
        next_rpt.ssf = ssf_f & ctrl_mon & ctrl_ssf_en;
        next_rpt.rdi = remote_defect & ~unequipped & ~trace_mismatch & ctrl_mon & ctrl_rdi_en;
    end

    // Report register and its previous value for edge events
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rpt <= '0;
            rpt_prev <= '0;
        end else begin
            rpt <= next_rpt;
            rpt_prev <= rpt;
        end
    end

    // APB decode
    logic wr_en, rd_setup, addr_hit;
    logic [4:0] int_sts, int_mask, int_set;
    logic [31:0] rd_val;

    assign wr_en = i_psel & i_penable & i_pwrite;
    assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
    assign addr_hit = (i_paddr[1:0] == 2'b00) && (i_paddr <= REG_INT_MASK);
    assign o_pready = 1'b1;
    // Unmapped addresses answer with an error
    assign o_pslverr = i_psel & i_penable & ~addr_hit;
    assign int_set = rpt & ~rpt_prev;

    // Configuration writes
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {ctrl_mon, ctrl_ssf_en, ctrl_rdi_en, ctrl_tim_dis, ctrl_fmt} <= 5'h00;
            exp_trace <= 8'h00;
            deg_thr <= DEG_THR_RESET;
            deg_m <= DEG_M_RESET;
            int_mask <= 5'h00;
        end else if (wr_en) begin
            case (i_paddr)
                REG_CTRL: begin
                    ctrl_mon <= i_pwdata[CTRL_MON_BIT];
                    ctrl_ssf_en <= i_pwdata[CTRL_SSF_EN_BIT];
                    ctrl_rdi_en <= i_pwdata[CTRL_RDI_EN_BIT];
                    ctrl_tim_dis <= i_pwdata[CTRL_TIM_DIS_BIT];
                    ctrl_fmt <= i_pwdata[CTRL_FMT_BIT];
                    exp_trace <= i_pwdata[CTRL_EXP_LSB +: 8];
                end
                REG_DEG: begin
                    deg_thr <= i_pwdata[15:0];
                    deg_m <= i_pwdata[DEG_M_LSB +: 4];
                end
                REG_INT_MASK: int_mask <= i_pwdata[4:0];
                default: int_mask <= int_mask;
            endcase
        end
    end

    // Sticky interrupt status, a new event beats a clear
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            int_sts <= 5'h00;
        end else if (wr_en && i_paddr == REG_INT_STS) begin
            int_sts <= (int_sts & ~i_pwdata[4:0]) | int_set;
        end else begin
            int_sts <= int_sts | int_set;
        end
    end

    // Level interrupt while any unmasked status bit stands
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(int_sts & int_mask);
        end
    end

    // Read multiplexer
    always_comb begin
        rd_val = 32'h0000_0000;
        case (i_paddr)
            REG_CTRL: rd_val = {16'h0000, exp_trace, 3'h0, ctrl_fmt, ctrl_tim_dis,
                ctrl_rdi_en, ctrl_ssf_en, ctrl_mon};
            REG_DEG: rd_val = {12'h000, deg_m, deg_thr};
            REG_STATUS: rd_val = {4'h0, o_remote_error_to_source, rx_trace, acc_trace,
                3'h0, rpt};
            REG_PM_DS: rd_val = {30'h0000_0000, pm_fds, pm_nds};
            REG_PM_NEBC: rd_val = 32'(pm_nebc);
            REG_PM_FEBC: rd_val = 32'(pm_febc);
            REG_INT_STS: rd_val = {27'h000_0000, int_sts};
            REG_INT_MASK: rd_val = {27'h000_0000, int_mask};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Read data captured in the setup cycle, held through access
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            o_prdata <= rd_val;
        end
    end

endmodule

`default_nettype wire

// File: rtl/pms_pkg.sv
// Shared constants and types for the VC-3 path overhead monitor sink
package pms_pkg;

    // Frame geometry: 9 rows of 85 columns, overhead in column 0
    localparam logic [6:0] LAST_COL = 7'h54;
    localparam logic [3:0] LAST_ROW = 4'h8;
    localparam logic [3:0] ROW_TRACE = 4'h0;
    localparam logic [3:0] ROW_PARITY = 4'h1;
    localparam logic [3:0] ROW_LABEL = 4'h2;
    localparam logic [3:0] ROW_STATUS = 4'h3;

    // Status byte fields (bit 1 of the byte is the MSB)
    localparam int unsigned REI_MSB = 7;
    localparam int unsigned REI_LSB = 4;
    localparam int unsigned RDI_BIT = 3;
    localparam logic [3:0] REI_MAX = 4'h8;

    // Data values
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [7:0] UNEQ_LABEL = 8'h00;

    // Persistence in frames
    localparam logic [2:0] TRACE_PERSIST = 3'h3;
    localparam logic [2:0] LABEL_PERSIST = 3'h5;
    localparam logic [2:0] RDI_PERSIST = 3'h5;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DEG = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_PM_DS = 8'h0c;
    localparam logic [7:0] REG_PM_NEBC = 8'h10;
    localparam logic [7:0] REG_PM_FEBC = 8'h14;
    localparam logic [7:0] REG_INT_STS = 8'h18;
    localparam logic [7:0] REG_INT_MASK = 8'h1c;

    // Control, degrade and status register fields
    localparam int unsigned CTRL_MON_BIT = 0;
    localparam int unsigned CTRL_SSF_EN_BIT = 1;
    localparam int unsigned CTRL_RDI_EN_BIT = 2;
    localparam int unsigned CTRL_TIM_DIS_BIT = 3;
    localparam int unsigned CTRL_FMT_BIT = 4;
    localparam int unsigned CTRL_EXP_LSB = 8;
    localparam int unsigned DEG_M_LSB = 16;
    localparam int unsigned STAT_ACC_LSB = 8;
    localparam int unsigned STAT_RX_LSB = 16;
    localparam int unsigned STAT_PV_LSB = 24;

    // Reset values
    localparam logic [15:0] DEG_THR_RESET = 16'h0020;
    localparam logic [3:0] DEG_M_RESET = 4'h2;

    // Incoming stream, as sampled by the reference clock
    typedef struct packed {
        logic clk;
        logic fs;
        logic ssf;
        logic [7:0] data;
    } pms_stream_s;

    // Correlated reports, also the interrupt layout
    typedef struct packed {
        logic ssf;
        logic rdi;
        logic deg;
        logic tim;
        logic uneq;
    } pms_report_s;

    // Frame alignment progress, Gray coded
    typedef enum logic [1:0] {
        FR_HUNT = 2'b00,
        FR_FIRST = 2'b01,
        FR_LOCKED = 2'b11
    } pms_frame_e;

endpackage

// File: testbench/pms_sink_asserts.sv
// Port checker for the path monitor sink
`timescale 1ns/100ps
`default_nettype none
module pms_sink_asserts
    import pms_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_server_signal_fail_in,
    input wire logic [7:0] o_data,
    input wire logic o_data_valid,
    input wire logic o_frame_start,
    input wire logic o_trail_signal_fail_out,
    input wire logic o_remote_defect_to_source,
    input wire logic [3:0] o_remote_error_to_source
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    a_fail_backrep: assert property (o_trail_signal_fail_out == o_remote_defect_to_source)
        else $error("fail and back-report differ");
    a_ssf_fail: assert property (i_server_signal_fail_in [*8] |-> o_trail_signal_fail_out)
        else $error("server fail not passed on");
    // Settled fail with no server fail behind it leaves only the forcing causes
    a_ais_data: assert property (o_data_valid && o_trail_signal_fail_out
        && $past(o_trail_signal_fail_out, 8) && !$past(i_server_signal_fail_in, 8)
        && !i_server_signal_fail_in |-> o_data == ALL_ONES)
        else $error("data not forced to ones");
    a_rei_range: assert property (o_remote_error_to_source <= REI_MAX)
        else $error("violation count above eight");
    a_valid_pulse: assert property (o_data_valid |=> !o_data_valid [*8])
        else $error("byte pulses too close");
    a_fs_valid: assert property ($rose(o_frame_start) |-> o_data_valid)
        else $error("frame start without byte");
    // Violation count only moves with a byte of the stream
    a_rei_byte: assert property ($changed(o_remote_error_to_source)
        |-> o_data_valid || $past(o_data_valid))
        else $error("violation count moved between bytes");
    a_data_hold: assert property (!o_data_valid |-> $stable(o_data))
        else $error("data moved between bytes");
    c_fail: cover property ($rose(o_trail_signal_fail_out));
    c_ones: cover property (o_data_valid && o_data == ALL_ONES);
    c_rei: cover property (o_remote_error_to_source != 4'h0);
endmodule
`default_nettype wire

// File: testbench/pms_stream_model.sv
// Upstream VC-3 stream source with overhead and parity
`timescale 1ns/100ps
`default_nettype none
module pms_stream_model
    import pms_pkg::*;
(
    input wire logic i_en,
    input wire logic i_ssf,
    input wire logic [7:0] i_trace,
    input wire logic [7:0] i_status,
    input wire logic [7:0] i_bip_flip,
    output pms_stream_s o_stream
);
    logic clk, fs;
    logic [7:0] data, bip, acc; // Byte, last frame parity, running parity
    int idx;
    assign o_stream = '{clk, fs, i_ssf, data};
    // Data moves at each falling byte clock so it is steady around each rising one
    initial begin
        clk = 1'b0;
        fs = 1'b0;
        data = 8'h00;
        bip = 8'h00;
        wait (i_en);
        forever begin
            for (idx = 0; idx < 765; idx++) begin
                // frame start marks the trace byte
                fs = (idx == 0);
                case (idx)
                    0: data = i_trace;
                    85: data = bip ^ i_bip_flip; // even parity, flipped on command
                    170: data = 8'h01; // Equipped label
                    255: data = i_status;
                    default: data = idx[7:0];
                endcase
                acc = (idx == 0) ? data : (acc ^ data);
                #80 clk = 1'b1;
                #80 clk = 1'b0;
            end
            bip = acc;
        end
    end
endmodule
`default_nettype wire

// File: testbench/test_pms_path_monitor_sink.sv
// Self-checking bench for the path monitor sink
`timescale 1ns/100ps
`default_nettype none
module test_pms_path_monitor_sink;
    import pms_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, one_sec, ssf, en, pready, pslverr, err;
    logic dv, fso, fail, degr, rdo, irq, eqd;
    logic [7:0] paddr, trace, status, flip, dout;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] rei;
    pms_stream_s st;
    int err_count = 0;
    int samples_checked = 0;
    pms_path_monitor_sink pms_path_monitor_sink_inst (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_stream_clk(st.clk), .i_stream_data(st.data), .i_frame_start(st.fs),
        .i_server_signal_fail_in(st.ssf), .i_equipment_defect(eqd), .i_one_second(one_sec),
        .o_data(dout), .o_data_valid(dv), .o_frame_start(fso), .o_trail_signal_fail_out(fail),
        .o_trail_signal_degrade_out(degr), .o_remote_defect_to_source(rdo),
        .o_remote_error_to_source(rei), .o_irq(irq));
    pms_stream_model pms_stream_model_inst (.i_en(en), .i_ssf(ssf), .i_trace(trace),
        .i_status(status), .i_bip_flip(flip), .o_stream(st));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // One transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        // Idle cycle so back-to-back calls never rewrite psel at one instant
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            err_count++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Counts output bytes, or frame starts when fs is set; bounded
    task automatic bytes(input int n, input logic fs);
        int c;
        for (c = 0; n > 0; c++) begin
            @(posedge clk);
            if (c > 40000) begin
                err_count++;
                tally_and_finish();
            end
            if (dv === 1'b1 && (!fs || fso === 1'b1)) n--;
        end
    endtask
    task automatic settle(ref logic s, input logic v);
        int c;
        for (c = 0; s !== v; c++) begin
            @(posedge clk);
            if (c > 100) chk("level wait", s, v);
            if (c > 100) tally_and_finish();
        end
    endtask
    task automatic t_setup();
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", err, 1'b1);
        // monitored, server fail reported, expected trace 0x33
        apb(1'b1, REG_CTRL, 32'h3303);
        apb(1'b1, REG_INT_MASK, 32'h2);
        bytes(2, 1'b1);
        chk("trace passes", dout, 8'h5a);
        flip <= 8'h07;
        status <= 8'h80;
        ssf <= 1'b1;
        settle(fail, 1'b1);
        chk("backreport", rdo, 1'b1);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("fail report", rd[4], 1'b1);
        ssf <= 1'b0;
        settle(fail, 1'b0);
        bytes(300, 1'b0);
        chk("violations", rei, 4'h3);
        flip <= 8'h00;
        $display("setup and parity done");
    endtask
    task automatic t_mismatch();
        bytes(1, 1'b1);
        status <= 8'h90;
        bytes(300, 1'b0);
        chk("mismatch fail", fail, 1'b1);
        bytes(1, 1'b0);
        chk("all ones", dout, ALL_ONES);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("accepted trace", rd[15:8], 8'h5a);
        chk("reports", rd[4:0], 5'h02);
        chk("irq raised", irq, 1'b1);
        apb(1'b1, REG_INT_STS, 32'h2);
        settle(irq, 1'b0);
        apb(1'b1, REG_CTRL, 32'h330b);
        settle(fail, 1'b0);
        chk("backreport off", rdo, 1'b0);
        bytes(1, 1'b1);
        chk("data restored", dout, 8'h5a);
        status <= 8'h10;
        $display("mismatch done");
    endtask
    task automatic t_counts();
        // Threshold of one block over a one-second window
        apb(1'b1, REG_DEG, 32'h0001_0001);
        bytes(300, 1'b0);
        one_sec <= 1'b1;
        @(posedge clk);
        one_sec <= 1'b0;
        apb(1'b0, REG_PM_NEBC, 32'h0);
        chk("near blocks", rd, 32'h1);
        apb(1'b0, REG_PM_FEBC, 32'h0);
        chk("far blocks", rd, 32'h2);
        apb(1'b0, REG_PM_DS, 32'h0);
        chk("defect seconds", rd, 32'h1);
        chk("degrade out", degr, 1'b1);
        eqd <= 1'b1;
        @(posedge clk);
        eqd <= 1'b0;
        one_sec <= 1'b1;
        @(posedge clk);
        one_sec <= 1'b0;
        apb(1'b0, REG_PM_DS, 32'h0);
        chk("equipment second", rd, 32'h1);
        $display("counts done");
    endtask
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        one_sec = 1'b0;
        eqd = 1'b0;
        ssf = 1'b0;
        en = 1'b0;
        trace = 8'h5a;
        status = 8'hf0;
        flip = 8'h00;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        en <= 1'b1;
        @(posedge clk);
        t_setup();
        t_mismatch();
        t_counts();
        tally_and_finish();
    end
endmodule
bind pms_path_monitor_sink pms_sink_asserts pms_sink_asserts_inst (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_server_signal_fail_in(i_server_signal_fail_in), .o_data(o_data),
    .o_data_valid(o_data_valid), .o_frame_start(o_frame_start),
    .o_trail_signal_fail_out(o_trail_signal_fail_out),
    .o_remote_defect_to_source(o_remote_defect_to_source),
    .o_remote_error_to_source(o_remote_error_to_source));
`default_nettype wire
